/* hdl/adc_conv_ctl.sv */
// Behaviour
// - A rising conv_select edge starts a conversion timed by the system clock.
// - Rising edges during a running conversion are ignored; no restart.
// - Between conversions: take config word, shift out result, keep acquiring.
// - SAR resolves the 16-bit word from MSB down to LSB.
// - Finished SAR word is copied into the output latch for readout.
// - Config word is 7 bits: SE, OS, HI, LO, COMMON_RETURN_SEL, UNIPOLAR_SEL, SLEEP_REQ.
// - Differential: pair k gives channels 2k/2k+1; OS swaps polarity.
// - Single-ended, no common: channel {HI,LO,OS} against ground.
// - Single-ended with common: channel 7 is negative, not selectable as positive.
// - Positive and negative inputs are sampled at the same instant.
// - Output is straight binary in unipolar, two's complement in bipolar.
// - Word shifted in while conv_select low applies to the next conversion.
// - SLEEP_REQ set enters sleep; 80 ms wake-up after release.
// - conv_select high at completion gives nap; low drives MSB, stays powered.
`timescale 1ns/1ps

module adc_conv_ctl #(
    parameter int unsigned WAKE_CYC = adc_ctl_pkg::WAKE_CYC
) (
    // System
    input wire logic clk_sys,
    input wire logic rstn,
    // Serial link
    input wire logic sck_link,
    input wire logic conv_select,
    input wire logic config_in,
    output logic result_out,
    output logic result_oe,
    // Analog front end
    input wire logic comp_in,
    output logic sample_hold,
    output logic [15:0] dac_word,
    output logic [2:0] mux_pos_ch,
    output logic mux_pos_en,
    output logic [2:0] mux_neg_ch,
    output logic mux_neg_gnd,
    output logic mux_neg_com,
    // Power and activity
    output logic conv_busy,
    output logic nap_mode,
    output logic sleep_mode,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    function automatic logic [15:0] bit_mask(input logic [3:0] idx);
        bit_mask = 16'h0001 << idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: config word capture

    logic [2:0] cnt_lk_ff;
    logic [6:0] cfg_shift_lk_ff;
    logic cfg_take_lk, cnt_clr_lk;

    // Reset clears it too, or the first frame after power-up counts from unknown
    assign cnt_clr_lk = conv_select | ~rstn;

    // Frame signal clears the count, since the shift clock stops between frames
    always_ff @(posedge sck_link or posedge cnt_clr_lk) begin
        if (cnt_clr_lk) begin
            cnt_lk_ff <= 3'h0;
        end else if (cfg_take_lk) begin
            cnt_lk_ff <= cnt_lk_ff + 3'h1;
        end
    end

    assign cfg_take_lk = (cnt_lk_ff != adc_ctl_pkg::CFG_CNT_FULL);

    // Only the first seven edges carry config; later ones only clock out data
    always_ff @(posedge sck_link or negedge rstn) begin
        if (!rstn) begin
            cfg_shift_lk_ff <= adc_ctl_pkg::CFG_RST;
        end else if (cfg_take_lk) begin
            cfg_shift_lk_ff <= {cfg_shift_lk_ff[5:0], config_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic cs_s1_ff, cs_s2_ff, cs_d_ff;
    logic sck_s1_ff, sck_s2_ff, sck_d_ff;
    logic comp_s1_ff, comp_s2_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cs_s1_ff <= 1'b0;
            cs_s2_ff <= 1'b0;
            cs_d_ff <= 1'b0;
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            sck_d_ff <= 1'b0;
        end else begin
            cs_s1_ff <= conv_select;
            cs_s2_ff <= cs_s1_ff;
            cs_d_ff <= cs_s2_ff;
            sck_s1_ff <= sck_link;
            sck_s2_ff <= sck_s1_ff;
            sck_d_ff <= sck_s2_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            comp_s1_ff <= 1'b0;
            comp_s2_ff <= 1'b0;
        end else begin
            comp_s1_ff <= comp_in;
            comp_s2_ff <= comp_s1_ff;
        end
    end

    logic cs_rise, sck_rise;
    assign cs_rise = cs_s2_ff & ~cs_d_ff;
    assign sck_rise = sck_s2_ff & ~sck_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    adc_ctl_pkg::conv_state_t state_ff, nxt_state;
    logic conv_en_ff;
    logic [6:0] cfg_ff;
    logic [6:0] new_cfg;
    logic start_ok, new_sleep, cfg_load, conv_start, wake_start, conv_done;

    // Word is quiet here: shift clock has stopped once the frame ended
    assign new_cfg = cfg_shift_lk_ff;
    assign new_sleep = new_cfg[adc_ctl_pkg::CFG_SLP];
    assign start_ok = cs_rise & conv_en_ff;
    assign cfg_load = start_ok & (state_ff != adc_ctl_pkg::CONV_SELECT);
    assign conv_start = start_ok & (state_ff == adc_ctl_pkg::CS_IDLE) & ~new_sleep;
    assign wake_start = start_ok & (state_ff == adc_ctl_pkg::CS_SLEEP) & ~new_sleep;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            adc_ctl_pkg::CS_IDLE: begin
                if (start_ok) begin
                    nxt_state = new_sleep ? adc_ctl_pkg::CS_SLEEP : adc_ctl_pkg::CONV_SELECT;
                end
            end
            adc_ctl_pkg::CONV_SELECT: begin
                if (conv_done) begin
                    nxt_state = adc_ctl_pkg::CS_IDLE;
                end
            end
            adc_ctl_pkg::CS_SLEEP: begin
                if (wake_start) begin
                    nxt_state = adc_ctl_pkg::CS_IDLE;
                end
            end
            default: begin
                nxt_state = adc_ctl_pkg::CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff <= adc_ctl_pkg::CS_IDLE;
            cfg_ff <= adc_ctl_pkg::CFG_RST;
        end else begin
            state_ff <= nxt_state;
            cfg_ff <= cfg_load ? new_cfg : cfg_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Successive approximation

    logic [15:0] sar_ff, sar_keep, sar_trial, fmt_word;
    logic [3:0] idx_ff;
    logic [3:0] step_ff;
    logic step_last;

    assign step_last = (step_ff == adc_ctl_pkg::STEP_LAST);
    assign conv_done = (state_ff == adc_ctl_pkg::CONV_SELECT) & step_last & (idx_ff == 4'h0);
    // Comparator high means input is above the trial level: keep the bit
    assign sar_keep = comp_s2_ff ? sar_ff : (sar_ff & ~bit_mask(idx_ff));
    assign sar_trial = (idx_ff != 4'h0) ? (sar_keep | bit_mask(idx_ff - 4'h1)) : sar_keep;
    // Offset binary becomes two's complement by inverting the top bit
    assign fmt_word = cfg_ff[adc_ctl_pkg::CFG_UNI] ? sar_keep : {~sar_keep[15], sar_keep[14:0]};

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sar_ff <= 16'h0000;
            idx_ff <= 4'h0;
            step_ff <= 4'h0;
        end else if (conv_start) begin
            sar_ff <= adc_ctl_pkg::SAR_MSB;
            idx_ff <= adc_ctl_pkg::IDX_MSB;
            step_ff <= 4'h0;
        end else if (state_ff == adc_ctl_pkg::CONV_SELECT) begin
            sar_ff <= step_last ? sar_trial : sar_ff;
            idx_ff <= step_last ? idx_ff - 4'h1 : idx_ff;
            step_ff <= step_last ? 4'h0 : step_ff + 4'h1;
        end
    end

    assign dac_word = sar_ff;
    // One hold strobe closes both inputs together
    assign sample_hold = (state_ff == adc_ctl_pkg::CONV_SELECT);
    assign conv_busy = (state_ff == adc_ctl_pkg::CONV_SELECT);
    assign sleep_mode = (state_ff == adc_ctl_pkg::CS_SLEEP);

    ////////////////////////////////////////////////////////////////////////////
    // Result latch and serial readout

    logic [15:0] result_ff, out_sr_ff;
    logic oe_ff, nap_ff, out_shift;

    // No shifting while converting: the data would be stale or half built
    assign out_shift = sck_rise & ~cs_s2_ff & (state_ff != adc_ctl_pkg::CONV_SELECT);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            result_ff <= 16'h0000;
            out_sr_ff <= 16'h0000;
        end else if (conv_done) begin
            result_ff <= fmt_word;
            out_sr_ff <= fmt_word;
        end else if (out_shift) begin
            out_sr_ff <= {out_sr_ff[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            oe_ff <= 1'b0;
            nap_ff <= 1'b0;
        end else begin
            oe_ff <= ~cs_s2_ff;
            nap_ff <= (conv_done & cs_s2_ff) | (nap_ff & cs_s2_ff);
        end
    end

    assign result_out = out_sr_ff[15];
    assign result_oe = oe_ff;
    assign nap_mode = nap_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Multiplexer decode

    logic se, os, common_return_sel;
    logic [2:0] chan;
    logic cfg_bad;

    assign se = cfg_ff[adc_ctl_pkg::CFG_SE];
    assign os = cfg_ff[adc_ctl_pkg::CFG_OS];
    assign common_return_sel = cfg_ff[adc_ctl_pkg::CFG_COM];
    assign chan = {cfg_ff[adc_ctl_pkg::CFG_HI], cfg_ff[adc_ctl_pkg::CFG_LO], os};
    // Channel 7 is the common return itself, so it cannot also be the input
    assign cfg_bad = (~se & common_return_sel) | (se & common_return_sel & (chan == 3'h7));
    assign mux_pos_ch = chan;
    assign mux_pos_en = ~cfg_bad;
    assign mux_neg_ch = se ? 3'h7 : {chan[2:1], ~os};
    assign mux_neg_gnd = se & ~common_return_sel;
    assign mux_neg_com = se & common_return_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Acquisition check and wake-up timer

    logic [6:0] acq_cnt_ff;
    logic acq_short_ff, acq_set, acq_clr;
    logic [22:0] wake_cnt_ff;
    logic waking;

    assign acq_set = conv_start & (acq_cnt_ff < adc_ctl_pkg::ACQ_W'(adc_ctl_pkg::ACQ_CYC));

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acq_cnt_ff <= adc_ctl_pkg::ACQ_W'(adc_ctl_pkg::ACQ_CYC);
        end else if (conv_done) begin
            acq_cnt_ff <= 7'h00;
        end else if (acq_cnt_ff < adc_ctl_pkg::ACQ_W'(adc_ctl_pkg::ACQ_CYC)) begin
            acq_cnt_ff <= acq_cnt_ff + 7'h01;
        end
    end

    // Set beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acq_short_ff <= 1'b0;
        end else begin
            acq_short_ff <= acq_set | (acq_short_ff & ~acq_clr);
        end
    end

    // Conversions are still allowed while waking; results are just not trusted
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wake_cnt_ff <= 23'h000000;
        end else if (wake_start) begin
            wake_cnt_ff <= adc_ctl_pkg::WAKE_W'(WAKE_CYC);
        end else if (waking) begin
            wake_cnt_ff <= wake_cnt_ff - 23'h000001;
        end
    end

    assign waking = (wake_cnt_ff != 23'h000000);

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    logic apb_setup, apb_acc, apb_wr;
    logic hit_ctrl, hit_status, hit_config, hit_result, addr_ok;
    logic [31:0] rd_mux, status_word;
    logic [31:0] prdata_ff;

    assign apb_setup = psel & ~penable;
    assign apb_acc = psel & penable;
    assign apb_wr = apb_acc & pwrite;
    assign hit_ctrl = (paddr == adc_ctl_pkg::REG_CTRL);
    assign hit_status = (paddr == adc_ctl_pkg::REG_STATUS);
    assign hit_config = (paddr == adc_ctl_pkg::REG_CONFIG);
    assign hit_result = (paddr == adc_ctl_pkg::REG_RESULT);
    assign addr_ok = hit_ctrl | hit_status | hit_config | hit_result;
    assign acq_clr = apb_wr & hit_status & pwdata[adc_ctl_pkg::ST_ACQ_SHORT];

    assign status_word = {26'h0000000, cfg_bad, waking, acq_short_ff, sleep_mode, nap_ff, conv_busy};
    assign rd_mux = hit_ctrl ? {31'h00000000, conv_en_ff} :
                    hit_status ? status_word :
                    hit_config ? {25'h0000000, cfg_ff} :
                    hit_result ? {16'h0000, result_ff} : 32'h00000000;

    // Read data is registered in the setup cycle so the access phase is fixed
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prdata_ff <= 32'h00000000;
        end else if (apb_setup) begin
            prdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            conv_en_ff <= adc_ctl_pkg::CTRL_EN_RST;
        end else if (apb_wr & hit_ctrl) begin
            conv_en_ff <= pwdata[adc_ctl_pkg::CTRL_EN];
        end
    end

    assign prdata = prdata_ff;
    assign pready = apb_acc;
    assign pslverr = apb_acc & ~addr_ok;

endmodule

/* hdl/adc_ctl_pkg.sv */
package adc_ctl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int SYS_CLK_MHZ = 50;
    localparam int T_CONV_NS = 3200;
    localparam int CONV_CYC = (T_CONV_NS * SYS_CLK_MHZ) / 1000;
    localparam real T_ACQ_US = 2.01;
    localparam int ACQ_CYC = int'($ceil(T_ACQ_US * SYS_CLK_MHZ));
    localparam int T_WAKE_MS = 80;
    localparam int WAKE_CYC = T_WAKE_MS * 1000 * SYS_CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and counts
    localparam int RES_BITS = 16;
    localparam int BIT_CYC = CONV_CYC / RES_BITS;
    localparam int STEP_W = 4;
    localparam int IDX_W = 4;
    localparam int ACQ_W = 7;
    localparam int WAKE_W = 23;
    localparam int CFG_BITS = 7;
    localparam logic [2:0] CFG_CNT_FULL = 3'h7;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(BIT_CYC - 1);
    localparam logic [IDX_W-1:0] IDX_MSB = 4'hf;
    localparam logic [15:0] SAR_MSB = 16'h8000;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration word layout, first bit shifted in is bit 6
    localparam int CFG_SE = 6;
    localparam int CFG_OS = 5;
    localparam int CFG_HI = 4;
    localparam int CFG_LO = 3;
    localparam int CFG_COM = 2;
    localparam int CFG_UNI = 1;
    localparam int CFG_SLP = 0;
    localparam logic [6:0] CFG_RST = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_CONFIG = 12'h008;
    localparam logic [11:0] REG_RESULT = 12'h00c;
    localparam int CTRL_EN = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_BUSY = 0;
    localparam int ST_NAP = 1;
    localparam int ST_SLEEP = 2;
    localparam int ST_ACQ_SHORT = 3;
    localparam int ST_WAKING = 4;
    localparam int ST_CFG_BAD = 5;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CONV_SELECT = 2'b01,
        CS_SLEEP = 2'b10
    } conv_state_t;

endpackage

/* dv/adc_conv_ctl_checker.sv */
`timescale 1ns/1ps
module adc_conv_ctl_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Link and front end
    input wire logic conv_select,
    input wire logic sample_hold,
    input wire logic [15:0] dac_word,
    input wire logic [2:0] mux_pos_ch,
    input wire logic mux_pos_en,
    input wire logic [2:0] mux_neg_ch,
    input wire logic mux_neg_gnd,
    input wire logic mux_neg_com,
    // Status
    input wire logic conv_busy,
    input wire logic nap_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    a_conv_len: assert property ($rose(conv_busy) |-> ##159 conv_busy ##1 !conv_busy)
        else $error("conversion length wrong");
    // A restart would reload the top trial bit shortly after the edge
    a_no_restart: assert property (conv_busy && $rose(conv_select) |=>
        (dac_word != 16'h8000 || $stable(dac_word))[*6])
        else $error("conversion restarted");
    a_msb_first: assert property ($rose(conv_busy) |-> dac_word == 16'h8000)
        else $error("first trial not msb");
    a_hold_busy: assert property (conv_busy |-> sample_hold)
        else $error("inputs not held during conversion");
    a_acq_after: assert property ($fell(conv_busy) |-> !sample_hold)
        else $error("no acquire after conversion");
    a_mux_pair: assert property (mux_pos_en && !mux_neg_gnd && !mux_neg_com |->
        mux_neg_ch == (mux_pos_ch ^ 3'h1))
        else $error("pair mismatch");
    a_mux_gnd: assert property (mux_neg_gnd |-> !mux_neg_com && mux_pos_en)
        else $error("ground return mixed");
    a_mux_com: assert property (mux_neg_com && mux_pos_en |-> mux_pos_ch != 3'h7)
        else $error("channel 7 as positive");
    a_mux_hold: assert property (conv_busy && $past(conv_busy) |->
        $stable(mux_pos_ch) && $stable(mux_neg_ch) && $stable(mux_neg_gnd))
        else $error("mux moved in conversion");
    a_nap_enter: assert property ($fell(conv_busy) && conv_select && $past(conv_select, 3) |->
        ##[0:2] nap_mode)
        else $error("no nap");
    a_stay_awake: assert property ($fell(conv_busy) && !conv_select && !$past(conv_select, 3) |->
        !nap_mode[*3])
        else $error("nap while low");
    c_nap: cover property ($rose(nap_mode));
    c_com7: cover property (mux_neg_com && !mux_pos_en);
    c_poke: cover property (conv_busy && $rose(conv_select));
endmodule
bind adc_conv_ctl adc_conv_ctl_checker u_chk (.clk_sys, .rstn, .conv_select, .sample_hold, .dac_word,
    .mux_pos_ch, .mux_pos_en, .mux_neg_ch, .mux_neg_gnd, .mux_neg_com, .conv_busy, .nap_mode);

/* dv/adc_host_model.sv */
`timescale 1ns/1ps
module adc_host_model (
    // System
    input wire logic clk_sys,
    // Link
    output logic sck_link,
    output logic conv_select,
    output logic config_in,
    input wire logic result_out,
    input wire logic result_oe,
    // Analog side
    input wire logic [15:0] dac_word,
    output logic comp_in
);
    logic [15:0] ain = 16'h0000;
    // Input sits half a code above ain, so the search lands on ain
    assign comp_in = (ain >= dac_word);
    initial begin
        sck_link = 1'b0;
        conv_select = 1'b0;
        config_in = 1'b0;
    end
    task automatic set_cs(input logic v);
        conv_select <= v;
    endtask
    // Shift clock stands still outside frames
    task automatic xfer(input logic [6:0] cfg, input logic [15:0] a, output logic [15:0] rd);
        @(posedge clk_sys);
        conv_select <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #7;
        for (int i = 0; i < 16; i++) begin
            config_in = (i < 7) ? cfg[6 - i] : ~config_in;
            #40 sck_link = 1'b1;
            // A released output reads as the inverse, so a missing enable shows up
            rd = {rd[14:0], result_oe ? result_out : ~result_out};
            #40 sck_link = 1'b0;
        end
        config_in = ~config_in;
        repeat (adc_ctl_pkg::ACQ_CYC) @(posedge clk_sys);
        ain = a;
        conv_select <= 1'b1;
    endtask
endmodule

/* dv/test_adc_mux_config_and_conversion_control.sv */
`timescale 1ns/1ps
module test_adc_mux_config_and_conversion_control;
    logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
    logic sck_link, conv_select, config_in, comp_in, result_out, result_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] dac_word;
    logic [2:0] mux_pos_ch, mux_neg_ch;
    logic mux_pos_en, mux_neg_gnd, mux_neg_com, sample_hold, conv_busy, nap_mode, sleep_mode;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    // Short wake count keeps the run brief
    adc_conv_ctl #(.WAKE_CYC(50)) dut (.clk_sys, .rstn, .sck_link, .conv_select, .config_in, .result_out,
        .result_oe, .comp_in, .sample_hold, .dac_word, .mux_pos_ch, .mux_pos_en, .mux_neg_ch,
        .mux_neg_gnd, .mux_neg_com, .conv_busy, .nap_mode, .sleep_mode, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    adc_host_model host (.clk_sys, .sck_link, .conv_select, .config_in, .result_out, .result_oe, .dac_word,
        .comp_in);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Waits as long as the slave stalls; only the bench timeout ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts busy cycles; optional early drop and mid-conversion edge
    task automatic wait_done(input logic pulse, input logic poke, output int n);
        n = 0;
        for (int k = 0; k < 400; k++) begin
            @(posedge clk_sys);
            if (pulse && k == 5) host.set_cs(1'b0);
            if (poke && k == 40) host.set_cs(1'b1);
            if (poke && k == 45) host.set_cs(1'b0);
            #1;
            if (conv_busy === 1'b1) n++;
            else if (n > 0) break;
        end
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic err;
        apb(1'b0, adc_ctl_pkg::REG_CTRL, 32'h0, r, err);
        chk(r, 32'h1);
        apb(1'b0, adc_ctl_pkg::REG_CONFIG, 32'h0, r, err);
        chk(r, 32'h0);
        apb(1'b0, adc_ctl_pkg::REG_STATUS, 32'h0, r, err);
        chk(r, 32'h0);
        chk(32'({mux_pos_en, mux_pos_ch, mux_neg_ch, mux_neg_gnd}), 32'h82);
        apb(1'b1, 12'h010, 32'hffffffff, r, err);
        chk(32'(err), 32'h1);
        $display("test reset done");
    endtask
    task automatic t_sweep();
        logic [6:0] cfg;
        logic [15:0] a, fmt, prev, rd;
        logic [2:0] pos;
        logic [31:0] r;
        logic err, common_return_sel;
        int n;
        for (int i = 0; i < 24; i++) begin
            cfg = (i < 16) ? {4'(i), 1'b0, i[0], 1'b0} : {1'b1, 3'(i), 1'b1, i[0], 1'b0};
            a = 16'h1234 + 16'(i) * 16'h0a5f;
            host.xfer(cfg, a, rd);
            if (i > 0) chk(32'(rd), 32'(prev));
            wait_done(!i[1], 1'b0, n);
            chk(32'(n), 32'(adc_ctl_pkg::CONV_CYC));
            fmt = cfg[1] ? a : {~a[15], a[14:0]};
            prev = fmt;
            chk(32'(nap_mode), 32'(i[1]));
            chk(32'(result_oe), 32'(!i[1]));
            if (!i[1]) chk(32'(result_out), 32'(fmt[15]));
            pos = {cfg[4:3], cfg[5]};
            common_return_sel = cfg[2];
            chk(32'({mux_pos_en, mux_neg_gnd, mux_neg_com}), 32'({!(common_return_sel && pos == 3'h7), cfg[6] && !common_return_sel, common_return_sel}));
            if (!(common_return_sel && pos == 3'h7)) chk(32'(mux_pos_ch), 32'(pos));
            if (!cfg[6]) chk(32'(mux_neg_ch), 32'({cfg[4:3], ~cfg[5]}));
            apb(1'b0, adc_ctl_pkg::REG_CONFIG, 32'h0, r, err);
            chk(r, 32'(cfg));
            apb(1'b0, adc_ctl_pkg::REG_RESULT, 32'h0, r, err);
            chk(r, 32'(fmt));
        end
        $display("test sweep done");
    endtask
    task automatic t_restart();
        logic [15:0] rd;
        logic [31:0] r;
        logic err;
        int n;
        host.xfer(7'h42, 16'h8001, rd);
        wait_done(1'b1, 1'b1, n);
        chk(32'(n), 32'(adc_ctl_pkg::CONV_CYC));
        // Restart right after the end leaves too little acquisition time
        @(posedge clk_sys);
        host.set_cs(1'b1);
        wait_done(1'b1, 1'b0, n);
        chk(32'(n), 32'(adc_ctl_pkg::CONV_CYC));
        apb(1'b0, adc_ctl_pkg::REG_STATUS, 32'h0, r, err);
        chk(32'(r[adc_ctl_pkg::ST_ACQ_SHORT]), 32'h1);
        apb(1'b1, adc_ctl_pkg::REG_STATUS, 32'h1 << adc_ctl_pkg::ST_ACQ_SHORT, r, err);
        apb(1'b0, adc_ctl_pkg::REG_STATUS, 32'h0, r, err);
        chk(32'(r[adc_ctl_pkg::ST_ACQ_SHORT]), 32'h0);
        apb(1'b1, adc_ctl_pkg::REG_CTRL, 32'h0, r, err);
        host.xfer(7'h42, 16'h0001, rd);
        chk(32'(rd), 32'h8001);
        wait_done(1'b1, 1'b0, n);
        chk(32'(n), 32'h0);
        apb(1'b1, adc_ctl_pkg::REG_CTRL, 32'h1, r, err);
        $display("test restart done");
    endtask
    task automatic t_sleep();
        logic [15:0] rd;
        logic [31:0] r;
        logic err;
        host.xfer(7'h43, 16'h0000, rd);
        repeat (10) @(posedge clk_sys);
        host.set_cs(1'b0);
        repeat (20) @(posedge clk_sys);
        #1;
        chk(32'({sleep_mode, conv_busy}), 32'h2);
        host.xfer(7'h42, 16'h0000, rd);
        repeat (10) @(posedge clk_sys);
        host.set_cs(1'b0);
        apb(1'b0, adc_ctl_pkg::REG_STATUS, 32'h0, r, err);
        #1;
        chk(32'({sleep_mode, r[adc_ctl_pkg::ST_WAKING]}), 32'h1);
        repeat (60) @(posedge clk_sys);
        apb(1'b0, adc_ctl_pkg::REG_STATUS, 32'h0, r, err);
        chk(32'(r[adc_ctl_pkg::ST_WAKING]), 32'h0);
        $display("test sleep done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_sweep();
        t_restart();
        t_sleep();
        results();
    end
    // Whole run is near 10000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            results();
        end
    end
endmodule
